// >>> rtl/lfr_cfg.svh
`ifndef LFR_CFG_SVH
`define LFR_CFG_SVH
// Register byte offsets
`define LFR_ADDR_ERROR 6'h00
`define LFR_ADDR_TIMING 6'h04
`define LFR_ADDR_BAUD 6'h08
`define LFR_ADDR_LENGTH 6'h0C
`define LFR_ADDR_IDENT 6'h10
`define LFR_ADDR_SELECT 6'h14
`define LFR_ADDR_DATA 6'h18
`define LFR_ADDR_CONTROL 6'h1C
`define LFR_ADDR_STATUS 6'h20
`define LFR_ADDR_IRQ_STAT 6'h24
`define LFR_ADDR_IRQ_CLR 6'h28
`define LFR_ADDR_IRQ_EN 6'h2C
// Field positions
`define LFR_ERR_ABORT 7
`define LFR_TIM_NORESYNC 7
`define LFR_SEL_NOINC 3
`define LFR_CTL_UART 0
`define LFR_CTL_OLDVER 1
`define LFR_STAT_SUMMARY 0
`define LFR_IRQ_ERROR 0
`define LFR_IRQ_RXBYTE 1
// Reset values and limits
`define LFR_SAMPLES_RESET 6'h20
`define LFR_SAMPLES_MIN 6'h08
`define LFR_LEN_MAX 4'h8
`define LFR_RESP_OKAY 2'h0
`define LFR_RESP_SLVERR 2'h2
`endif

// >>> rtl/lfr_pkg.sv
package lfr_pkg;
  typedef logic [7:0] lfr_byte_t;
  typedef logic [5:0] lfr_addr_t;
  typedef enum logic {LFR_MODE_LIN, LFR_MODE_UART} lfr_mode_t;
endpackage : lfr_pkg

// >>> rtl/lfr_frame_regs.sv
// Notes on behaviour
// - Read-only eight error flags, zero after reset
// - Abort command sets the abort warning flag
// - Flags stick until summary flag cleared
// - Resync on edges unless disable bit set
// - Six-bit samples per bit, 32/8/63
// - Sample period is clock times divider+1
// - Transmit length upper nibble, clamped to eight
// - Receive length lower nibble, clamped to eight
// - Identifier parity bits computed read-only
// - Old version length code 2/2/4/8 bytes
// - Old four-bit id, new six-bit id
// - Index auto-advances per data access unless disabled or in UART mode
// - Three-bit index selects buffered response byte
// - Data port is buffer or single UART byte
// - Summary flag ORs flags, write one clears
// - Version bit: 0 newer, 1 older
`include "lfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lfr_frame_regs
  import lfr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire lfr_pkg::lfr_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire lfr_pkg::lfr_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lfr_pkg::lfr_byte_t errEvent,
  input wire logic rxEdge,
  input wire logic rxByteValid,
  input wire logic [2:0] rxByteIndex,
  input wire lfr_pkg::lfr_byte_t rxByte,
  input wire logic [2:0] bufReadIndex,
  output lfr_pkg::lfr_byte_t bufReadData,
  output logic uartRxValid,
  output logic uartTxStart,
  output lfr_pkg::lfr_byte_t uartTxData,
  output lfr_pkg::lfr_mode_t linkMode,
  output logic oldVersion,
  output logic sampleTick,
  output logic bitTick,
  output logic [3:0] txLength,
  output logic [3:0] rxLength,
  output logic [3:0] idLength,
  output logic [5:0] frameId,
  output logic irq
);
  import lfr_pkg::*;
  logic [7:0] errorFlags;
  logic resyncDisable;
  logic [5:0] samplesPerBit;
  logic [11:0] baudDivisor;
  lfr_byte_t responseLength;
  logic [5:0] idBits;
  logic noAutoIncrement;
  logic [2:0] bufferIndex;
  lfr_byte_t respBuf [8];
  lfr_byte_t uartRxHold;
  logic uartMode;
  logic [1:0] irqStatus;
  logic [1:0] irqEnable;
  logic [11:0] divCnt;
  logic [5:0] sampleCnt;
  logic awHeld;
  logic wHeld;
  lfr_addr_t wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrEn;
  logic rdEn;
  logic lane0;
  logic errClear;
  logic dataWr;
  logic dataRd;
  logic [5:0] effSamples;
  logic [1:0] idParity;
  logic [1:0] irqEvent;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic wrMapped;
  logic timingWr;

  assign wrEn = awHeld && wHeld && !s_axi_bvalid;
  assign rdEn = s_axi_arvalid && s_axi_arready;
  assign lane0 = wrStrb[0];
  assign errClear = wrEn && lane0 && wrAddr == `LFR_ADDR_STATUS
    && wrData[`LFR_STAT_SUMMARY];
  assign dataWr = wrEn && lane0 && wrAddr == `LFR_ADDR_DATA;
  assign dataRd = rdEn && s_axi_araddr == `LFR_ADDR_DATA;
  // Values below the minimum would make a bit shorter than the voter needs
  assign effSamples = (samplesPerBit < `LFR_SAMPLES_MIN) ?
    `LFR_SAMPLES_MIN : samplesPerBit;
  assign idParity[0] = idBits[4] ^ idBits[2] ^ idBits[1]
    ^ idBits[0];
  assign idParity[1] = !(idBits[1] ^ idBits[3] ^ idBits[4]
    ^ idBits[5]);
  assign irqEvent[`LFR_IRQ_ERROR] = |errEvent;
  assign irqEvent[`LFR_IRQ_RXBYTE] = uartMode && rxByteValid;
  assign wrMapped = wrAddr <= `LFR_ADDR_IRQ_EN;
  assign timingWr = wrEn && lane0 && wrAddr == `LFR_ADDR_TIMING;

  // Write address and data may arrive in either order
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LFR_RESP_OKAY;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (wrEn)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `LFR_RESP_OKAY : `LFR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb
  begin
    next_rdata = '0;
    next_rresp = `LFR_RESP_OKAY;
    if (s_axi_araddr == `LFR_ADDR_ERROR)
      next_rdata[7:0] = errorFlags;
    else if (s_axi_araddr == `LFR_ADDR_TIMING)
      next_rdata[7:0] = {resyncDisable, 1'b0, samplesPerBit};
    else if (s_axi_araddr == `LFR_ADDR_BAUD)
      next_rdata[15:0] = {4'h0, baudDivisor};
    else if (s_axi_araddr == `LFR_ADDR_LENGTH)
      next_rdata[7:0] = responseLength;
    else if (s_axi_araddr == `LFR_ADDR_IDENT)
      next_rdata[7:0] = {idParity, idBits};
    else if (s_axi_araddr == `LFR_ADDR_SELECT)
      next_rdata[7:0] = {4'h0, noAutoIncrement, bufferIndex};
    else if (s_axi_araddr == `LFR_ADDR_DATA)
      next_rdata[7:0] = uartMode ? uartRxHold
        : respBuf[bufferIndex];
    else if (s_axi_araddr == `LFR_ADDR_CONTROL)
      next_rdata[1:0] = {oldVersion, uartMode};
    else if (s_axi_araddr == `LFR_ADDR_STATUS)
      next_rdata[0] = |errorFlags;
    else if (s_axi_araddr == `LFR_ADDR_IRQ_STAT)
      next_rdata[1:0] = irqStatus;
    else if (s_axi_araddr == `LFR_ADDR_IRQ_CLR)
      next_rdata = '0;
    else if (s_axi_araddr == `LFR_ADDR_IRQ_EN)
      next_rdata[1:0] = irqEnable;
    else
      next_rresp = `LFR_RESP_SLVERR;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `LFR_RESP_OKAY;
    end
    else if (rdEn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      errorFlags <= 8'h00;
    else
      errorFlags <= (errClear ? 8'h00 : errorFlags)
        | errEvent;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      resyncDisable <= 1'b0;
      samplesPerBit <= `LFR_SAMPLES_RESET;
      baudDivisor <= 12'h000;
      responseLength <= 8'h00;
      idBits <= 6'h00;
      noAutoIncrement <= 1'b0;
      uartMode <= 1'b0;
      oldVersion <= 1'b0;
      irqEnable <= 2'h0;
    end
    else if (wrEn)
    begin
      if (wrAddr == `LFR_ADDR_TIMING && lane0)
      begin
        resyncDisable <= wrData[`LFR_TIM_NORESYNC];
        samplesPerBit <= wrData[5:0];
      end
      else if (wrAddr == `LFR_ADDR_BAUD)
      begin
        // Upper nibble is not stored
        if (lane0)
          baudDivisor[7:0] <= wrData[7:0];
        if (wrStrb[1])
          baudDivisor[11:8] <= wrData[11:8];
      end
      else if (wrAddr == `LFR_ADDR_LENGTH && lane0)
        responseLength <= wrData[7:0];
      else if (wrAddr == `LFR_ADDR_IDENT && lane0)
        idBits <= wrData[5:0];
      else if (wrAddr == `LFR_ADDR_SELECT && lane0)
        noAutoIncrement <= wrData[`LFR_SEL_NOINC];
      else if (wrAddr == `LFR_ADDR_CONTROL && lane0)
      begin
        uartMode <= wrData[`LFR_CTL_UART];
        oldVersion <= wrData[`LFR_CTL_OLDVER];
      end
      else if (wrAddr == `LFR_ADDR_IRQ_EN && lane0)
        irqEnable <= wrData[1:0];
    end
  end

  // A read and a write of the data port in one cycle advance by two
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      bufferIndex <= 3'h0;
    else if (wrEn && lane0 && wrAddr == `LFR_ADDR_SELECT)
      bufferIndex <= wrData[2:0];
    else if (!uartMode && !noAutoIncrement)
      bufferIndex <= bufferIndex + {2'h0, dataWr}
        + {2'h0, dataRd};
  end

  // The frame engine's own byte wins over a software write
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 8; i++)
        respBuf[i] <= 8'h00;
    end
    else if (rxByteValid && !uartMode)
      respBuf[rxByteIndex] <= rxByte;
    else if (dataWr && !uartMode)
      respBuf[bufferIndex] <= wrData[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      uartRxHold <= 8'h00;
      uartRxValid <= 1'b0;
      uartTxStart <= 1'b0;
      uartTxData <= 8'h00;
    end
    else
    begin
      uartTxStart <= dataWr && uartMode;
      if (dataWr && uartMode)
        uartTxData <= wrData[7:0];
      if (rxByteValid && uartMode)
      begin
        uartRxHold <= rxByte;
        uartRxValid <= 1'b1;
      end
      else if (dataRd && uartMode)
        uartRxValid <= 1'b0;
    end
  end

  // A new timing restarts the bit, so the count stays below it
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      divCnt <= 12'h000;
      sampleCnt <= 6'h00;
      sampleTick <= 1'b0;
      bitTick <= 1'b0;
    end
    else if ((rxEdge && !resyncDisable) || timingWr)
    begin
      divCnt <= 12'h000;
      sampleCnt <= 6'h00;
      sampleTick <= 1'b0;
      bitTick <= 1'b0;
    end
    else
    begin
      sampleTick <= divCnt == baudDivisor;
      bitTick <= divCnt == baudDivisor && sampleCnt == effSamples - 6'h01;
      if (divCnt == baudDivisor)
      begin
        divCnt <= 12'h000;
        sampleCnt <= (sampleCnt >= effSamples - 6'h01) ? 6'h00
          : sampleCnt + 6'h01;
      end
      else
        divCnt <= divCnt + 12'h001;
    end
  end

  // Frame engine view, registered so outputs come from flops
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      txLength <= 4'h0;
      rxLength <= 4'h0;
      idLength <= 4'h2;
      frameId <= 6'h00;
      linkMode <= LFR_MODE_LIN;
      bufReadData <= 8'h00;
    end
    else
    begin
      txLength <= (responseLength[7:4] > `LFR_LEN_MAX) ? `LFR_LEN_MAX
        : responseLength[7:4];
      rxLength <= (responseLength[3:0] > `LFR_LEN_MAX) ? `LFR_LEN_MAX
        : responseLength[3:0];
      idLength <= idBits[5] ? (idBits[4] ? 4'h8 : 4'h4) : 4'h2;
      frameId <= oldVersion ? {2'h0, idBits[3:0]} : idBits;
      linkMode <= uartMode ? LFR_MODE_UART : LFR_MODE_LIN;
      bufReadData <= respBuf[bufReadIndex];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irqStatus <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      irqStatus <= ((wrEn && lane0 && wrAddr == `LFR_ADDR_IRQ_CLR) ?
        irqStatus & ~wrData[1:0] : irqStatus) | irqEvent;
      irq <= |(irqStatus & irqEnable);
    end
  end

  sequence s_idx_access;
    !uartMode && !noAutoIncrement && (dataWr ^ dataRd)
      && !(wrEn && lane0 && wrAddr == `LFR_ADDR_SELECT);
  endsequence

  property p_err_reset;
    @(posedge ref_clk) sys_rst |=> errorFlags == 8'h00;
  endproperty
  a_err_reset: assert property (p_err_reset)
    else $error("error flags not zero after reset");

  property p_abort_set;
    @(posedge ref_clk) disable iff (sys_rst)
      errEvent[`LFR_ERR_ABORT] |=> errorFlags[`LFR_ERR_ABORT];
  endproperty
  a_abort_set: assert property (p_abort_set)
    else $error("abort flag not set");

  property p_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
      !errClear |=> (errorFlags & $past(errorFlags)) == $past(errorFlags);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag dropped without clear");

  property p_clear_set_wins;
    @(posedge ref_clk) disable iff (sys_rst)
      errClear |=> errorFlags == $past(errEvent);
  endproperty
  a_clear_set_wins: assert property (p_clear_set_wins)
    else $error("summary clear wrong");

  property p_resync;
    @(posedge ref_clk) disable iff (sys_rst)
      rxEdge && !resyncDisable |=> divCnt == 12'h000 && sampleCnt == 6'h00;
  endproperty
  a_resync: assert property (p_resync)
    else $error("no resync on edge");

  property p_sample_period;
    @(posedge ref_clk) disable iff (sys_rst)
      sampleTick |-> divCnt == 12'h000;
  endproperty
  a_sample_period: assert property (p_sample_period)
    else $error("sample tick off period");

  property p_samples_min;
    @(posedge ref_clk) disable iff (sys_rst)
      sampleCnt < effSamples && effSamples >= `LFR_SAMPLES_MIN;
  endproperty
  a_samples_min: assert property (p_samples_min)
    else $error("sample count out of range");

  property p_len_clamp;
    @(posedge ref_clk) disable iff (sys_rst)
      (responseLength[7:4] > 4'h8 |=> txLength == 4'h8)
      and (responseLength[3:0] > 4'h8 |=> rxLength == 4'h8);
  endproperty
  a_len_clamp: assert property (p_len_clamp)
    else $error("length above eight");

  property p_old_len;
    @(posedge ref_clk) disable iff (sys_rst)
      idBits[5:4] == 2'h3 ##1 $stable(idBits) |-> idLength == 4'h8;
  endproperty
  a_old_len: assert property (p_old_len)
    else $error("length code decode wrong");

  property p_auto_inc;
    @(posedge ref_clk) disable iff (sys_rst)
      s_idx_access |=> bufferIndex == $past(bufferIndex) + 3'h1;
  endproperty
  a_auto_inc: assert property (p_auto_inc)
    else $error("index did not advance");

  property p_id_old;
    @(posedge ref_clk) disable iff (sys_rst)
      oldVersion ##1 oldVersion && $stable(idBits) |-> frameId[5:4] == 2'h0;
  endproperty
  a_id_old: assert property (p_id_old)
    else $error("old identifier not four bits");
endmodule : lfr_frame_regs
`default_nettype wire

// >>> testbench/lfr_frame_peer.sv
`timescale 1ns/1ps
`default_nettype none
module lfr_frame_peer
  import lfr_pkg::*;
(
  input wire logic ref_clk,
  output var lfr_pkg::lfr_byte_t errEvent,
  output var logic rxEdge,
  output var logic rxByteValid,
  output var logic [2:0] rxByteIndex,
  output var lfr_pkg::lfr_byte_t rxByte,
  output var logic [2:0] bufReadIndex
);
  import lfr_pkg::*;
  initial
  begin
    errEvent = 8'h00;
    rxEdge = 1'b0;
    rxByteValid = 1'b0;
    rxByteIndex = 3'h0;
    rxByte = 8'hA5;
    bufReadIndex = 3'h0;
  end
  // One-cycle events, as the frame engine gives them
  task automatic pulse_err(input lfr_byte_t m);
    @(posedge ref_clk);
    errEvent <= m;
    @(posedge ref_clk);
    errEvent <= 8'h00;
  endtask : pulse_err
  // Byte lines turn over once released, no stale value
  task automatic send_rx(input logic [2:0] i, input lfr_byte_t b);
    @(posedge ref_clk);
    rxByteValid <= 1'b1;
    rxByteIndex <= i;
    rxByte <= b;
    @(posedge ref_clk);
    rxByteValid <= 1'b0;
    rxByte <= ~b;
  endtask : send_rx
  task automatic pulse_edge;
    @(posedge ref_clk);
    rxEdge <= 1'b1;
    @(posedge ref_clk);
    rxEdge <= 1'b0;
  endtask : pulse_edge
  task automatic look(input logic [2:0] i);
    @(posedge ref_clk);
    bufReadIndex <= i;
    repeat (2) @(posedge ref_clk);
  endtask : look
endmodule : lfr_frame_peer
`default_nettype wire

// >>> testbench/lfr_frame_regs_tb.sv
`include "lfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lfr_frame_regs_tb;
  import lfr_pkg::*;
  logic ref_clk, sys_rst;
  lfr_addr_t s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, txLength, rxLength, idLength;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, rxEdge, rxByteValid;
  lfr_byte_t errEvent, rxByte, bufReadData, uartTxData, txByte;
  logic uartRxValid, uartTxStart, oldVersion, sampleTick, bitTick, irq;
  logic [2:0] rxByteIndex, bufReadIndex;
  lfr_mode_t linkMode;
  logic [5:0] frameId;
  int errTotal, nChecks, txSeen, n;
  lfr_byte_t ids [4] = '{8'h00, 8'h3F, 8'h15, 8'h2A};
  int lens [4] = '{2, 2, 4, 8};

  lfr_frame_regs dut_u (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .errEvent, .rxEdge,
    .rxByteValid, .rxByteIndex, .rxByte, .bufReadIndex, .bufReadData,
    .uartRxValid, .uartTxStart, .uartTxData, .linkMode, .oldVersion,
    .sampleTick, .bitTick, .txLength, .rxLength, .idLength, .frameId,
    .irq);
  lfr_frame_peer peer_u (.ref_clk, .errEvent, .rxEdge, .rxByteValid,
    .rxByteIndex, .rxByte, .bufReadIndex);

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (uartTxStart === 1'b1)
    begin
      txSeen++;
      txByte = uartTxData;
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic wr(input lfr_addr_t a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge ref_clk);
      if (!aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdc(input lfr_addr_t a, input logic [31:0] e,
    input string nm);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(nm, e, rd);
  endtask : rdc

  task automatic period(input logic useBit);
    do @(posedge ref_clk); while ((useBit ? bitTick : sampleTick) !== 1'b1);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while ((useBit ? bitTick : sampleTick) !== 1'b1);
  endtask : period

  // Edge two clocks after a tick; gap counts clocks to the next tick
  task automatic after_edge;
    period(1'b0);
    peer_u.pulse_edge();
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (sampleTick !== 1'b1);
  endtask : after_edge

  function automatic lfr_byte_t par(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[4] ^ i[2] ^ i[1] ^ i[0], i};
  endfunction : par

  initial
  begin
    #3000000;
    errTotal++;
    end_of_test();
  end

  initial
  begin
    errTotal = 0;
    nChecks = 0;
    txSeen = 0;
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(`LFR_ADDR_ERROR, 32'h0, "error");
    rdc(`LFR_ADDR_TIMING, 32'h20, "timing");
    rdc(`LFR_ADDR_BAUD, 32'h0, "baud");
    rdc(`LFR_ADDR_LENGTH, 32'h0, "length");
    chk("idLength", 32'h2, idLength);
    // Sticky flags, summary, interrupt raise, mask and clear
    wr(`LFR_ADDR_IRQ_EN, 32'h1);
    peer_u.pulse_err(8'h80);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h1, irq);
    rdc(`LFR_ADDR_ERROR, 32'h80, "error");
    peer_u.pulse_err(8'h05);
    peer_u.pulse_err(8'h42);
    rdc(`LFR_ADDR_ERROR, 32'hC7, "error");
    rdc(`LFR_ADDR_STATUS, 32'h1, "status");
    wr(`LFR_ADDR_STATUS, 32'h1);
    rdc(`LFR_ADDR_ERROR, 32'h0, "error");
    rdc(`LFR_ADDR_STATUS, 32'h0, "status");
    wr(`LFR_ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, irq);
    wr(`LFR_ADDR_IRQ_EN, 32'h1);
    wr(`LFR_ADDR_IRQ_CLR, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, irq);
    rdc(`LFR_ADDR_IRQ_STAT, 32'h0, "irqStat");
    // Timing, divider and length fields
    wr(`LFR_ADDR_TIMING, 32'hBF);
    rdc(`LFR_ADDR_TIMING, 32'hBF, "timing");
    wr(`LFR_ADDR_BAUD, 32'h0FFF);
    rdc(`LFR_ADDR_BAUD, 32'h0FFF, "baud");
    // Each byte lane alone: the other lane keeps its bits
    s_axi_wstrb <= 4'h2;
    wr(`LFR_ADDR_BAUD, 32'h0009);
    rdc(`LFR_ADDR_BAUD, 32'h00FF, "baud");
    s_axi_wstrb <= 4'h1;
    wr(`LFR_ADDR_BAUD, 32'h0F09);
    s_axi_wstrb <= 4'hF;
    rdc(`LFR_ADDR_BAUD, 32'h0009, "baud");
    period(1'b0);
    period(1'b0);
    chk("samplePeriod", 32'd10, n);
    // Held timing gives a gap of 8, restarted timing a gap of 11
    after_edge();
    chk("resyncGap", 32'd8, n);
    wr(`LFR_ADDR_TIMING, 32'h3F);
    after_edge();
    chk("resyncGap", 32'd11, n);
    wr(`LFR_ADDR_BAUD, 32'h0002);
    period(1'b0);
    period(1'b0);
    chk("samplePeriod", 32'd3, n);
    // Five samples act as eight: a bit of 8 x 3 clocks
    wr(`LFR_ADDR_TIMING, 32'h05);
    period(1'b1);
    period(1'b1);
    chk("bitPeriod", 32'd24, n);
    wr(`LFR_ADDR_LENGTH, 32'hA3);
    repeat (2) @(posedge ref_clk);
    chk("txLength", 32'h8, txLength);
    chk("rxLength", 32'h3, rxLength);
    wr(`LFR_ADDR_LENGTH, 32'h5C);
    repeat (2) @(posedge ref_clk);
    chk("txLength", 32'h5, txLength);
    chk("rxLength", 32'h8, rxLength);
    // Identifier parity and six-bit id, then old-version length code and four-bit id
    for (int k = 0; k < 4; k++)
    begin
      wr(`LFR_ADDR_IDENT, {24'h0, 2'b11, ids[k][5:0]});
      rdc(`LFR_ADDR_IDENT, par(ids[k][5:0]), "ident");
      chk("frameId", ids[k][5:0], frameId);
    end
    wr(`LFR_ADDR_CONTROL, 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      wr(`LFR_ADDR_IDENT, {26'h0, k[1:0], 4'h9});
      repeat (2) @(posedge ref_clk);
      chk("oldVersion", 32'h1, oldVersion);
      chk("idLength", lens[k], idLength);
      chk("frameId", 32'h9, frameId);
    end
    wr(`LFR_ADDR_CONTROL, 32'h0);
    // Buffer index advance, wrap and hold
    wr(`LFR_ADDR_SELECT, 32'h06);
    wr(`LFR_ADDR_DATA, 32'h11);
    wr(`LFR_ADDR_DATA, 32'h22);
    wr(`LFR_ADDR_DATA, 32'h33);
    rdc(`LFR_ADDR_SELECT, 32'h01, "select");
    peer_u.look(3'h7);
    chk("buf7", 32'h22, bufReadData);
    peer_u.look(3'h0);
    chk("buf0", 32'h33, bufReadData);
    wr(`LFR_ADDR_SELECT, 32'h0A);
    wr(`LFR_ADDR_DATA, 32'h44);
    wr(`LFR_ADDR_DATA, 32'h55);
    rdc(`LFR_ADDR_SELECT, 32'h0A, "select");
    peer_u.look(3'h2);
    chk("buf2", 32'h55, bufReadData);
    wr(`LFR_ADDR_SELECT, 32'h05);
    peer_u.send_rx(3'h5, 8'h96);
    rdc(`LFR_ADDR_DATA, 32'h96, "data");
    rdc(`LFR_ADDR_SELECT, 32'h06, "select");
    // Single unbuffered byte in UART mode
    wr(`LFR_ADDR_CONTROL, 32'h1);
    txSeen = 0;
    wr(`LFR_ADDR_DATA, 32'h5A);
    repeat (3) @(posedge ref_clk);
    chk("linkMode", 32'h1, linkMode);
    chk("txStarts", 32'h1, txSeen);
    chk("txByte", 32'h5A, txByte);
    peer_u.send_rx(3'h0, 8'hC3);
    repeat (2) @(posedge ref_clk);
    chk("rxValid", 32'h1, uartRxValid);
    rdc(`LFR_ADDR_IRQ_STAT, 32'h2, "irqStat");
    rdc(`LFR_ADDR_DATA, 32'hC3, "data");
    repeat (2) @(posedge ref_clk);
    chk("rxValid", 32'h0, uartRxValid);
    // Unmapped place answers with an error
    rdc(6'h30, 32'h0, "unmapped");
    chk("rresp", `LFR_RESP_SLVERR, rsp);
    wr(6'h30, 32'h1);
    chk("bresp", `LFR_RESP_SLVERR, rsp);
    end_of_test();
  end
endmodule : lfr_frame_regs_tb
`default_nettype wire
